/* misd_pkg.sv */
// Constants, types and decode helpers for the instruction subset decoder.
// Assumes a single hclk domain and a 32-bit AHB-Lite register port.
// Functional notes
// - Increment-skip-zero adds one to f, result to working register or f, no flags.
// - Zero result of increment-skip-zero discards prefetched word, runs a no-op cycle.
// - Increment-skip-nonzero increments f, no flags; nonzero result skips next word.
// - OR-literal ORs working register with literal, updates zero flag only, one cycle.
// - OR-register ORs working register with f into chosen destination, zero flag only.
// - File-to-peripheral copies f to p; peripheral-to-file copies p to f, sets zero.
// - Window moves reach all 256 bytes with f; p covers only 00h to 1Fh.
// - Window operands may be working register or indirect; resolved by normal access path.
// - Bank loads write low or high nibble of bank select, other nibble kept.
// - Literal load puts literal in working register in one cycle, no flags.
// - Multiplies give unsigned 16-bit product in product pair; operands and flags kept.
package misd_pkg;
  // Instruction phases
  typedef enum logic [1:0] {
    PH_DECODE = 2'b00,
    PH_READ   = 2'b01,
    PH_PROC   = 2'b10,
    PH_WRITE  = 2'b11
  } misd_phase_t;
  // Decoded operations
  typedef enum logic [3:0] {
    OP_NOP   = 4'b0000,
    OP_INCSZ = 4'b0001,
    OP_INSNZ = 4'b0010,
    OP_ORL   = 4'b0011,
    OP_ORF   = 4'b0100,
    OP_CALL  = 4'b0101,
    OP_FTOP  = 4'b0110,
    OP_PTOF  = 4'b0111,
    OP_BNKLO = 4'b1000,
    OP_BNKHI = 4'b1001,
    OP_LDL   = 4'b1010,
    OP_STF   = 4'b1011,
    OP_MULL  = 4'b1100,
    OP_MULF  = 4'b1101
  } misd_op_t;
  // Instruction word fields
  localparam int DEST_BIT   = 8;
  localparam int LIT_HI     = 7;
  localparam int NIB_LO_HI  = 3;
  localparam int NIB_HI_LO  = 4;
  localparam int P_HI       = 12;
  localparam int P_LO       = 8;
  localparam int OPC8_LO    = 8;
  localparam int OPC7_LO    = 9;
  localparam int OPC3_LO    = 13;
  localparam logic [7:0] OPC8_ORL   = 8'hB3;
  localparam logic [7:0] OPC8_CALL  = 8'hB7;
  localparam logic [7:0] OPC8_BNKLO = 8'hB8;
  localparam logic [7:0] OPC8_LDL   = 8'hB0;
  localparam logic [7:0] OPC8_STF   = 8'h01;
  localparam logic [7:0] OPC8_MULL  = 8'hBC;
  localparam logic [7:0] OPC8_MULF  = 8'h34;
  localparam logic [6:0] OPC7_INCSZ = 7'h0F;
  localparam logic [6:0] OPC7_INSNZ = 7'h12;
  localparam logic [6:0] OPC7_ORF   = 7'h04;
  localparam logic [6:0] OPC7_BNKHI = 7'h5D;
  localparam logic [2:0] OPC3_FTOP  = 3'h3;
  localparam logic [2:0] OPC3_PTOF  = 3'h2;
  // Data space map
  localparam logic [7:0] WORK_ADDR  = 8'h0A;
  localparam logic [7:0] IND_ADDR   = 8'h00;
  localparam logic [7:0] P_MAX_ADDR = 8'h1F;
  localparam logic [7:0] ZERO8      = 8'h00;
  // Reset values
  localparam logic [15:0] RESET_PC  = 16'h0000;
  localparam logic        RESET_RUN = 1'b1;
  // AHB-Lite register map
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_WORK   = 8'h08;
  localparam logic [7:0] OFF_BANK   = 8'h0C;
  localparam logic [7:0] OFF_PRLO   = 8'h10;
  localparam logic [7:0] OFF_PRHI   = 8'h14;
  localparam logic [7:0] OFF_PC     = 8'h18;
  localparam logic [7:0] OFF_LATCH  = 8'h1C;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACT_BIT = 1;

  // Map an instruction word onto one operation of the subset
  function automatic misd_op_t misd_decode(input logic [15:0] w);
    misd_op_t o;
    o = OP_NOP;
    if (w[15:OPC3_LO] == OPC3_FTOP) o = OP_FTOP;
    else if (w[15:OPC3_LO] == OPC3_PTOF) o = OP_PTOF;
    else if (w[15:OPC8_LO] == OPC8_ORL) o = OP_ORL;
    else if (w[15:OPC8_LO] == OPC8_CALL) o = OP_CALL;
    else if (w[15:OPC8_LO] == OPC8_BNKLO) o = OP_BNKLO;
    else if (w[15:OPC8_LO] == OPC8_LDL) o = OP_LDL;
    else if (w[15:OPC8_LO] == OPC8_STF) o = OP_STF;
    else if (w[15:OPC8_LO] == OPC8_MULL) o = OP_MULL;
    else if (w[15:OPC8_LO] == OPC8_MULF) o = OP_MULF;
    else if (w[15:OPC7_LO] == OPC7_INCSZ) o = OP_INCSZ;
    else if (w[15:OPC7_LO] == OPC7_INSNZ) o = OP_INSNZ;
    else if (w[15:OPC7_LO] == OPC7_ORF) o = OP_ORF;
    else if (w[15:OPC7_LO] == OPC7_BNKHI) o = OP_BNKHI;
    return o;
  endfunction
endpackage

/* misd_exec_if.sv */
// Carrier between the decoder core, the address resolver and the multiplier.
// Assumes all members are combinational within one hclk cycle.
`timescale 1ns/1ns
interface misd_exec_if;
  logic [7:0]  raw_addr;
  logic [7:0]  ind_ptr;
  logic [7:0]  phys_addr;
  logic        is_work;
  logic [7:0]  mul_a;
  logic [7:0]  mul_b;
  logic [15:0] mul_prod;
  modport core    (output raw_addr, ind_ptr, mul_a, mul_b, input phys_addr, is_work, mul_prod);
  modport resolve (input raw_addr, ind_ptr, output phys_addr, is_work);
  modport mult    (input mul_a, mul_b, output mul_prod);
endinterface

/* misd_addr_resolve.sv */
// Register-file address resolver: indirect slot and working-register alias.
// Assumes the core time-shares raw_addr between source and destination.
`timescale 1ns/1ns
module misd_addr_resolve
  import misd_pkg::*;
(
  misd_exec_if.resolve ex  // Address request and answer
);
  // Indirect slot takes the pointer, then the alias check runs on the result
  always_comb begin
    ex.phys_addr = (ex.raw_addr == IND_ADDR) ? ex.ind_ptr : ex.raw_addr;
    ex.is_work   = (ex.phys_addr == WORK_ADDR);
  end
endmodule

/* misd_mult.sv */
// Unsigned 8x8 multiplier for the product register pair.
// Assumes operands are stable through the process and write phases.
`timescale 1ns/1ns
module misd_mult
  import misd_pkg::*;
(
  misd_exec_if.mult ex  // Operands and product
);
  // Zero-extended so the full 16-bit product survives
  assign ex.mul_prod = {8'h00, ex.mul_a} * {8'h00, ex.mul_b};
endmodule

/* misd_core.sv */
// Instruction subset decoder and executor with an AHB-Lite status port.
// Assumes single-cycle program and data memory reads, one hclk domain.
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
module misd_core
  import misd_pkg::*;
(
  input  wire logic        hclk,       // System clock
  input  wire logic        hresetn,    // Async reset, active low
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write strobe
  input  wire logic [2:0]  hsize,      // Transfer size
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic        hready,     // Bus ready
  output logic             hreadyout,  // Slave ready
  output logic             hresp,      // Slave response
  output logic [31:0]      hrdata,     // Read data
  output logic [15:0]      prog_addr,  // Program fetch address
  input  wire logic [15:0] prog_data,  // Fetched instruction word
  output logic [7:0]       dm_addr,    // Data memory address
  output logic [7:0]       dm_wdata,   // Data memory write data
  output logic             dm_re,      // Data memory read enable
  output logic             dm_we,      // Data memory write enable
  input  wire logic [7:0]  dm_rdata,   // Data memory read data
  input  wire logic [7:0]  ind_ptr,    // Indirect pointer value
  output logic             stack_push, // Stack push pulse
  output logic [15:0]      stack_top   // Value pushed
);
  misd_phase_t q;
  misd_op_t    op;
  misd_op_t    op_now;
  logic [15:0] ir;
  logic        ir_valid;
  logic [15:0] pc;
  logic [7:0]  working_register;
  logic [7:0]  bank_select_register;
  logic [7:0]  product_high;
  logic [7:0]  product_low;
  logic [7:0]  pc_high_latch;
  logic        status_z;
  logic        ctrl_run;
  logic [7:0]  opnd;
  logic [7:0]  result_q;
  logic [7:0]  next_result;
  logic        work_we_q;
  logic        ahb_wr_pend;
  logic [7:0]  ahb_waddr;
  logic [7:0]  ir_lit;
  logic [3:0]  lit_lo;
  logic [3:0]  lit_hi;
  logic [3:0]  bsr_lo;
  logic [3:0]  bsr_hi;
  logic [7:0]  f_addr;
  logic [7:0]  p_addr;
  logic [7:0]  src_addr;
  logic [7:0]  dst_addr;
  logic        adv;
  logic        reads_mem;
  logic        wr_file;
  logic        wr_w_direct;
  logic        flush;
  logic        ahb_take;
  misd_exec_if ex ();

  misd_addr_resolve i_misd_addr_resolve (
    .ex (ex)
  );
  misd_mult i_misd_mult (
    .ex (ex)
  );

  // Instruction fields and operand addresses
  assign ir_lit   = ir[LIT_HI:0];
  assign lit_lo   = ir[NIB_LO_HI:0];
  assign lit_hi   = ir[LIT_HI:NIB_HI_LO];
  assign bsr_lo   = bank_select_register[NIB_LO_HI:0];
  assign bsr_hi   = bank_select_register[LIT_HI:NIB_HI_LO];
  assign f_addr   = ir[LIT_HI:0];
  assign p_addr   = {3'h0, ir[P_HI:P_LO]};
  // Source follows the word in ir only: op still holds the previous one in phase one
  assign src_addr = (op_now == OP_PTOF) ? p_addr : f_addr;
  assign dst_addr = (op == OP_FTOP) ? p_addr : f_addr;
  assign adv      = ctrl_run;
  assign op_now   = ir_valid ? misd_decode(ir) : OP_NOP;

  // Source address in the first half, destination in the second
  assign ex.raw_addr = (q == PH_DECODE || q == PH_READ) ? src_addr : dst_addr;
  assign ex.ind_ptr  = ind_ptr;
  assign ex.mul_a    = working_register;
  assign ex.mul_b    = (op == OP_MULL) ? ir_lit : opnd;

  // Read class of the word in ir, destination classes of the latched operation
  always_comb begin
    reads_mem = (op_now == OP_INCSZ) || (op_now == OP_INSNZ) || (op_now == OP_ORF) ||
                (op_now == OP_FTOP) || (op_now == OP_PTOF) || (op_now == OP_MULF);
    wr_file = (((op == OP_INCSZ) || (op == OP_INSNZ) || (op == OP_ORF)) && ir[DEST_BIT]) ||
              (op == OP_FTOP) || (op == OP_PTOF) || (op == OP_STF);
    wr_w_direct = (((op == OP_INCSZ) || (op == OP_INSNZ) || (op == OP_ORF)) &&
                   !ir[DEST_BIT]) || (op == OP_ORL) || (op == OP_LDL);
    flush = ((op == OP_INCSZ) && (result_q == ZERO8)) ||
            ((op == OP_INSNZ) && (result_q != ZERO8)) ||
            (op == OP_CALL);
  end

  // Result of the process phase
  always_comb begin
    case (op)
      OP_INCSZ, OP_INSNZ: next_result = opnd + 8'h01;
      OP_ORL:             next_result = working_register | ir_lit;
      OP_ORF:             next_result = working_register | opnd;
      OP_FTOP, OP_PTOF:   next_result = opnd;
      OP_LDL:             next_result = ir_lit;
      OP_STF:             next_result = working_register;
      default:            next_result = ZERO8;
    endcase
  end

  // Phase sequencer, stalls while run is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= PH_DECODE;
    end else if (adv) begin
      case (q)
        PH_DECODE: q <= PH_READ;
        PH_READ:   q <= PH_PROC;
        PH_PROC:   q <= PH_WRITE;
        PH_WRITE:  q <= PH_DECODE;
        default:   q <= PH_DECODE;
      endcase
    end
  end

  // Decode, operand read and process registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op       <= OP_NOP;
      opnd     <= ZERO8;
      result_q <= ZERO8;
    end else if (adv) begin
      if (q == PH_DECODE) begin
        op <= op_now;
      end
      if (q == PH_READ) begin
        opnd <= ex.is_work ? working_register : dm_rdata;
      end
      if (q == PH_PROC) begin
        result_q <= next_result;
      end
    end
  end

  // Data memory port: read in phase two, write strobe in phase four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dm_addr  <= ZERO8;
      dm_wdata <= ZERO8;
      dm_re    <= 1'b0;
      dm_we    <= 1'b0;
    end else if (adv) begin
      case (q)
        PH_DECODE: begin
          dm_addr <= ex.phys_addr;
          dm_re   <= reads_mem;
        end
        PH_READ: begin
          dm_re <= 1'b0;
        end
        PH_PROC: begin
          dm_addr  <= ex.phys_addr;
          dm_wdata <= next_result;
          dm_we    <= wr_file && !ex.is_work;
        end
        PH_WRITE: begin
          dm_we <= 1'b0;
        end
        default: begin
          dm_we <= 1'b0;
        end
      endcase
    end
  end

  // Working register, written only at the end of the write phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      working_register <= ZERO8;
      work_we_q        <= 1'b0;
    end else if (adv) begin
      if (q == PH_PROC) begin
        work_we_q <= wr_w_direct || (wr_file && ex.is_work);
      end
      if (q == PH_WRITE && work_we_q) begin
        working_register <= result_q;
      end
    end
  end

  // Zero flag touched only by the OR ops and peripheral-to-file move
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_z <= 1'b0;
    end else if (adv && q == PH_WRITE) begin
      if (op == OP_ORL || op == OP_ORF || op == OP_PTOF) begin
        status_z <= (result_q == ZERO8);
      end
    end
  end

  // Bank select nibble loads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_select_register <= ZERO8;
    end else if (adv && q == PH_WRITE) begin
      if (op == OP_BNKLO) begin
        bank_select_register <= {bsr_hi, lit_lo};
      end else if (op == OP_BNKHI) begin
        bank_select_register <= {lit_hi, bsr_lo};
      end
    end
  end

  // Product register pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      product_high <= ZERO8;
      product_low  <= ZERO8;
    end else if (adv && q == PH_WRITE && (op == OP_MULL || op == OP_MULF)) begin
      {product_high, product_low} <= ex.mul_prod;
    end
  end

  // Fetch pipeline, program counter and call push
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir         <= 16'h0000;
      ir_valid   <= 1'b0;
      pc         <= RESET_PC;
      stack_push <= 1'b0;
      stack_top  <= 16'h0000;
    end else begin
      stack_push <= adv && q == PH_WRITE && op == OP_CALL;
      if (adv && q == PH_WRITE) begin
        ir       <= prog_data;
        ir_valid <= !flush;
        if (op == OP_CALL) begin
          stack_top <= pc;
          pc        <= {pc_high_latch, ir_lit};
        end else begin
          pc <= pc + 16'h0001;
        end
      end
    end
  end
  assign prog_addr = pc;

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ahb_take  = hsel && hready && htrans[HTRANS_ACT_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_pend   <= 1'b0;
      ahb_waddr     <= ZERO8;
      hrdata        <= 32'h00000000;
      ctrl_run      <= RESET_RUN;
      pc_high_latch <= ZERO8;
    end else begin
      if (ahb_wr_pend) begin
        case (ahb_waddr)
          OFF_CTRL:   ctrl_run      <= hwdata[CTRL_RUN_BIT];
          OFF_LATCH:  pc_high_latch <= hwdata[LIT_HI:0];
          default:    ctrl_run      <= ctrl_run;
        endcase
      end
      ahb_wr_pend <= ahb_take && hwrite && (hsize == HSIZE_WORD);
      if (ahb_take) begin
        ahb_waddr <= haddr[7:0];
      end
      if (ahb_take && !hwrite) begin
        case (haddr[7:0])
          OFF_CTRL:   hrdata <= 32'(ctrl_run);
          OFF_STATUS: hrdata <= 32'({q, ir_valid, status_z});
          OFF_WORK:   hrdata <= 32'(working_register);
          OFF_BANK:   hrdata <= 32'(bank_select_register);
          OFF_PRLO:   hrdata <= 32'(product_low);
          OFF_PRHI:   hrdata <= 32'(product_high);
          OFF_PC:     hrdata <= 32'(pc);
          OFF_LATCH:  hrdata <= 32'(pc_high_latch);
          default:    hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // One skipped cycle: no valid instruction, no memory write
  sequence s_nop_cycle;
    (!ir_valid && !dm_we) [*4];
  endsequence
  sequence s_write_edge(misd_op_t o);
    adv && q == PH_WRITE && op == o;
  endsequence

  property p_inc_dest;
    s_write_edge(OP_INCSZ) ##0 !ir[DEST_BIT]
      |=> working_register == $past(result_q) && $stable(status_z);
  endproperty
  a_inc_dest: assert property (p_inc_dest) else $error("inc result not in working reg");

  property p_skip_zero;
    s_write_edge(OP_INCSZ) ##0 result_q == ZERO8 |=> s_nop_cycle;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero skip missing");

  property p_skip_nonzero;
    s_write_edge(OP_INSNZ) ##0 result_q != ZERO8 |=> s_nop_cycle;
  endproperty
  a_skip_nonzero: assert property (p_skip_nonzero) else $error("nonzero skip missing");

  property p_or_lit;
    adv && q == PH_PROC && op == OP_ORL
      |=> result_q == ($past(working_register) | $past(ir_lit));
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("or literal wrong");

  property p_or_reg_file;
    adv && q == PH_PROC && op == OP_ORF && ir[DEST_BIT] && !ex.is_work
      |=> dm_we && dm_wdata == ($past(working_register) | $past(opnd));
  endproperty
  a_or_reg_file: assert property (p_or_reg_file) else $error("or register write wrong");

  property p_long_call;
    s_write_edge(OP_CALL) |=> stack_push && stack_top == $past(pc) &&
      prog_addr == {$past(pc_high_latch), $past(ir_lit)} ##0 s_nop_cycle;
  endproperty
  a_long_call: assert property (p_long_call) else $error("long call wrong");

  property p_p_to_f_zero;
    s_write_edge(OP_PTOF) |=> status_z == ($past(result_q) == ZERO8);
  endproperty
  a_p_to_f_zero: assert property (p_p_to_f_zero) else $error("move zero flag wrong");

  property p_p_range;
    q == PH_PROC && op == OP_FTOP |-> ex.raw_addr <= P_MAX_ADDR;
  endproperty
  a_p_range: assert property (p_p_range) else $error("p address out of window");

  property p_work_alias;
    adv && q == PH_PROC && wr_file && ex.is_work |=> !dm_we ##3 $stable(dm_we);
  endproperty
  a_work_alias: assert property (p_work_alias) else $error("alias wrote memory");

  property p_bank_low;
    s_write_edge(OP_BNKLO) |=> bsr_lo == $past(lit_lo) && bsr_hi == $past(bsr_hi);
  endproperty
  a_bank_low: assert property (p_bank_low) else $error("bank low load wrong");

  property p_bank_high;
    s_write_edge(OP_BNKHI) |=> bsr_hi == $past(lit_hi) && bsr_lo == $past(bsr_lo);
  endproperty
  a_bank_high: assert property (p_bank_high) else $error("bank high load wrong");

  property p_lit_load;
    s_write_edge(OP_LDL) |=> working_register == $past(ir_lit) && $stable(status_z);
  endproperty
  a_lit_load: assert property (p_lit_load) else $error("literal load wrong");

  property p_mult;
    s_write_edge(OP_MULF) or s_write_edge(OP_MULL)
      |=> {product_high, product_low} == $past(ex.mul_prod) &&
          $stable(working_register) && $stable(status_z);
  endproperty
  a_mult: assert property (p_mult) else $error("product wrong");

  property p_store;
    adv && q == PH_PROC && op == OP_STF && !ex.is_work
      |=> dm_we && dm_wdata == $past(working_register) && dm_addr == $past(ex.phys_addr);
  endproperty
  a_store: assert property (p_store) else $error("register store wrong");

  property p_write_phase;
    // Rising strobe only, a run freeze in the write phase holds the strobe high
    $rose(dm_we) || $changed(working_register) |-> $past(q) == PH_PROC || q == PH_DECODE;
  endproperty
  a_write_phase: assert property (p_write_phase) else $error("write outside last phase");
endmodule

/* test_mcu_instruction_subset_decode.sv */
// Self-checking bench for the instruction subset decoder.
// Assumes a zero-wait AHB-Lite slave and a combinational data memory.
`timescale 1ns/1ns
module test_mcu_instruction_subset_decode;
  import misd_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] prog_data = 16'h0;
  logic [7:0]  ind_ptr = 8'h70;
  logic        hreadyout, hresp, dm_re, dm_we, stack_push;
  logic [31:0] hrdata, rd;
  logic [15:0] prog_addr, stack_top;
  logic [7:0]  dm_addr, dm_wdata, dm_rdata;
  logic [15:0] pmem [0:511];
  logic [7:0]  dmem [0:255];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_push = 0;
  int          n_rd = 0;

  misd_core i_misd_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prog_addr(prog_addr),
    .prog_data(prog_data), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_re(dm_re),
    .dm_we(dm_we), .dm_rdata(dm_rdata), .ind_ptr(ind_ptr), .stack_push(stack_push),
    .stack_top(stack_top));

  // Clock, 8 ns period
  always #4 hclk = ~hclk;
  // Program word follows the fetch address one edge later
  always @(posedge hclk) prog_data <= pmem[prog_addr[8:0]];
  assign dm_rdata = dmem[dm_addr];
  // Data memory writes and push counting
  always @(posedge hclk) begin
    if (dm_we) dmem[dm_addr] <= dm_wdata;
    if (stack_push) n_push <= n_push + 1;
    if (dm_re) n_rd <= n_rd + 1;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single AHB-Lite word transfer, read data left in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    for (n = 0; n < 50 && hreadyout !== 1'b1; n++) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    for (n = 0; n < 50 && hreadyout !== 1'b1; n++) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Wait for a fetch address, then halt the core
  task automatic wait_pc(input logic [15:0] a);
    int n;
    for (n = 0; n < 2000 && prog_addr !== a; n++) @(posedge hclk);
    chk("prog_addr", {16'h0, a}, {16'h0, prog_addr});
    ahb(1'b1, OFF_CTRL, 32'h0);
  endtask

  // Read one register and compare
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Reset values, unmapped place and latch setup
  task automatic t_reset;
    rchk("ctrl", OFF_CTRL, 32'h1);
    rchk("pc_latch", OFF_LATCH, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    ahb(1'b1, OFF_LATCH, 32'h1);
    rchk("pc_latch_wr", OFF_LATCH, 32'h1);
    $display("test reset done");
  endtask

  // Literal ops, multiply, bank nibbles, and the run freeze
  task automatic t_literal;
    logic [15:0] pa;
    wait_pc(16'h0008);
    rchk("work", OFF_WORK, 32'hC4);
    rchk("prod_hi", OFF_PRHI, 32'hAD);
    rchk("prod_lo", OFF_PRLO, 32'h08);
    rchk("bank", OFF_BANK, 32'h75);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk("zero_flag", 32'h0, {31'h0, rd[0]});
    pa = prog_addr;
    repeat (8) @(posedge hclk);
    chk("frozen_pc", {16'h0, pa}, {16'h0, prog_addr});
    ahb(1'b1, OFF_CTRL, 32'h1);
    $display("test literal done");
  endtask

  // Skips, OR to file, window moves, indirect slot, register multiply
  task automatic t_file;
    wait_pc(16'h0018);
    chk("store", 32'hC4, {24'h0, dmem[8'h50]});
    chk("inc_wrap", 32'h00, {24'h0, dmem[8'h40]});
    chk("zero_skip", 32'h05, {24'h0, dmem[8'h41]});
    chk("no_skip", 32'h06, {24'h0, dmem[8'h51]});
    chk("nz_skip", 32'h17, {24'h0, dmem[8'h43]});
    chk("to_periph", 32'h17, {24'h0, dmem[8'h1A]});
    chk("to_high", 32'h17, {24'h0, dmem[8'hF0]});
    chk("indirect", 32'h00, {24'h0, dmem[8'h60]});
    rchk("work_alias", OFF_WORK, 32'h17);
    rchk("prod_lo_f", OFF_PRLO, 32'h11);
    rchk("prod_hi_f", OFF_PRHI, 32'h02);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk("zero_set", 32'h1, {31'h0, rd[0]});
    ahb(1'b1, OFF_CTRL, 32'h1);
    $display("test file done");
  endtask

  // Long call through the high latch
  task automatic t_call;
    wait_pc(16'h0143);
    rchk("call_target", OFF_WORK, 32'hA5);
    chk("reads", 32'h9, n_rd);
    chk("pushes", 32'h1, n_push);
    chk("stack_top", 32'h1A, {16'h0, stack_top});
    chk("flushed", 32'h00, {24'h0, dmem[8'h52]});
    ahb(1'b1, OFF_CTRL, 32'h1);
    $display("test call done");
  endtask

  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Program load, reset and test sequence
  initial begin
    for (int i = 0; i < 512; i++) pmem[i] = 16'h0;
    for (int i = 0; i < 256; i++) dmem[i] = 8'h0;
    dmem[8'h40] = 8'hFF;
    dmem[8'h41] = 8'h05;
    dmem[8'h43] = 8'h13;
    // Slot 00h and the indirect target differ so a missed redirect shows
    dmem[8'h00] = 8'h5A;
    dmem[8'h60] = 8'hEE;
    pmem[0] = 16'hB09A;
    pmem[1] = 16'hB335;
    pmem[2] = 16'hB0C4;
    pmem[3] = 16'hBCE2;
    pmem[4] = 16'hB8F5;
    pmem[5] = 16'hBB7F;
    pmem[9] = 16'h0150;
    pmem[10] = 16'h1F40;
    pmem[11] = 16'h0141;
    pmem[12] = 16'h1E41;
    pmem[13] = 16'h0151;
    pmem[14] = 16'h2441;
    pmem[15] = 16'hB033;
    pmem[16] = 16'h0943;
    pmem[17] = 16'h7A43;
    pmem[18] = 16'h6A43;
    pmem[19] = 16'h5AF0;
    pmem[20] = 16'h3443;
    pmem[21] = 16'h4060;
    pmem[25] = 16'hB740;
    pmem[26] = 16'h0152;
    pmem[320] = 16'hB0A5;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_literal;
    t_file;
    t_call;
    conclude;
  end

  // Watchdog
  initial begin
    #160000;
    n_mismatch++;
    conclude;
  end
endmodule
